// file: rtl/synth_control_registers.sv
// Write-only control register bank of an integer-N synthesizer.
// Assumes the serial clock, data and latch enable are synchronous
// to core_clk and each last at least one core_clk cycle per level.
`timescale 1ns/100ps

// How it works
// - Normal pump current from bits 3..0.
// - Fast pump current from bits 9..6.
// - Codes 0-7 give code+1 steps; 8 half.
// - Prescaler codes 1,2,3 select 16,32,64.
// - Lock count codes map to 7,15,31,63.
// - Fast fields ignored unless enable set.
// - Tristate bit turns pump output off.
// - Polarity bit: 0 positive, 1 negative.
// - Lock detect source: 0 digital, 1 analog.
// - Fast current held duration times PD period.
// - Bit 1 drives second general output.
// - Bit 0 drives first general output.
// - Pump and reference words wait for divider write.
// - Function and output words apply at once.
module synth_control_registers #(
  parameter int DUR_BITS = 13
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Three-wire serial link
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic latch_enable,
  // Phase detector timing
  input wire logic pdTick,
  // Applied settings
  output synth_ctrl_pkg::synth_settings_t settings,
  output logic general_output_one,
  output logic general_output_two
);

  // ==========================================================
  // Reset release
  logic rstMeta_reg;
  logic rstSync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_n <= rstMeta_reg;
    end
  end

  // ==========================================================
  // Serial shifter
  logic [synth_ctrl_pkg::FRAME_BITS-1:0] shift_reg;
  logic sclkPrev_reg;
  logic lePrev_reg;
  logic sclkRise;
  logic leRise;
  assign sclkRise = serialClk && !sclkPrev_reg;
  assign leRise = latch_enable && !lePrev_reg;

  // Edge history of the link pins
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sclkPrev_reg <= 1'b0;
      lePrev_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= serialClk;
      lePrev_reg <= latch_enable;
    end
  end

  // Shift MSB first; the last four bits are the address
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      shift_reg <= '0;
    end else if (sclkRise) begin
      shift_reg <= {shift_reg[synth_ctrl_pkg::FRAME_BITS-2:0], serialData};
    end
  end

  logic [3:0] frameAddr;
  logic [19:0] frameData;
  assign frameAddr = shift_reg[3:0];
  assign frameData = shift_reg[synth_ctrl_pkg::FRAME_BITS-1:4];

  // ==========================================================
  // Staged words and write pulses
  logic [19:0] pumpBuf_reg;
  logic [19:0] refBuf_reg;
  logic [19:0] pumpLive_reg;
  logic [19:0] refLive_reg;
  logic [19:0] func_reg;
  logic [18:0] divLive_reg;
  logic commit_reg;

  // Buffered words; only a divider write moves them to the live copy
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pumpBuf_reg <= synth_ctrl_pkg::WORD_RESET;
      refBuf_reg <= synth_ctrl_pkg::WORD_RESET;
      pumpLive_reg <= synth_ctrl_pkg::WORD_RESET;
      refLive_reg <= synth_ctrl_pkg::WORD_RESET;
      divLive_reg <= '0;
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= 1'b0;
      if (leRise) begin
        case (frameAddr)
          synth_ctrl_pkg::ADDR_PUMP: pumpBuf_reg <= frameData;
          synth_ctrl_pkg::ADDR_REFPRE: refBuf_reg <= frameData;
          synth_ctrl_pkg::ADDR_DIVIDER: begin
            pumpLive_reg <= pumpBuf_reg;
            refLive_reg <= refBuf_reg;
            divLive_reg <= frameData[18:0];
            commit_reg <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Immediate words: function and general outputs
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      func_reg <= synth_ctrl_pkg::WORD_RESET;
      general_output_one <= 1'b0;
      general_output_two <= 1'b0;
    end else if (leRise) begin
      if (frameAddr == synth_ctrl_pkg::ADDR_FUNCTION) begin
        func_reg <= frameData;
      end
      if (frameAddr == synth_ctrl_pkg::ADDR_GENOUT) begin
        general_output_one <= frameData[synth_ctrl_pkg::GEN_ONE_BIT];
        general_output_two <= frameData[synth_ctrl_pkg::GEN_TWO_BIT];
      end
    end
  end

  // ==========================================================
  // Fields
  logic [3:0] normal_pump_current;
  logic [3:0] fast_pump_current;
  logic [1:0] prescaleCode;
  logic [1:0] lock_count_select;
  logic fast_lock_enable;
  logic [DUR_BITS-1:0] fastDuration;
  assign normal_pump_current = pumpLive_reg[synth_ctrl_pkg::NORMAL_CUR_LSB +: 4];
  assign fast_pump_current = pumpLive_reg[synth_ctrl_pkg::FAST_CUR_LSB +: 4];
  assign prescaleCode = refLive_reg[synth_ctrl_pkg::PRESCALE_LSB +: 2];
  assign lock_count_select = func_reg[synth_ctrl_pkg::LOCK_CNT_LSB +: 2];
  assign fast_lock_enable = func_reg[synth_ctrl_pkg::FAST_EN_BIT];
  assign fastDuration = func_reg[synth_ctrl_pkg::FAST_DUR_LSB +: DUR_BITS];

  // ==========================================================
  // Fast lockup timer
  logic fastActive;
  fast_lock_timer #(
    .DUR_BITS(DUR_BITS)
  ) timer (
    .core_clk(core_clk),
    .rstSync_n(rstSync_n),
    .start(commit_reg),
    .enable(fast_lock_enable),
    .pdTick(pdTick),
    .duration(fastDuration),
    .active(fastActive)
  );

  // ==========================================================
  // Decoded settings, registered to the outputs
  synth_ctrl_pkg::synth_settings_t settingsNext;
  logic [3:0] activeCode;
  always_comb begin
    activeCode = (fast_lock_enable && fastActive) ? fast_pump_current
                                                  : normal_pump_current;
    settingsNext = '0;
    settingsNext.activeCurCode = activeCode;
    // Half steps keep code 8 exact as one half step
    if (activeCode == synth_ctrl_pkg::CUR_HALF_CODE) begin
      settingsNext.curHalfSteps = 5'h01;
    end else if (activeCode <= synth_ctrl_pkg::CUR_MAX_LINEAR) begin
      // Widened first so code 7 gives 16 half steps, not a wrapped 0
      settingsNext.curHalfSteps = {1'b0, activeCode[2:0], 1'b0} + 5'h02;
    end else begin
      settingsNext.curHalfSteps = 5'h00;  // Undefined codes give no current
    end
    settingsNext.pumpTristate = func_reg[synth_ctrl_pkg::TRISTATE_BIT];
    settingsNext.pumpPolarity = func_reg[synth_ctrl_pkg::POLARITY_BIT];
    settingsNext.lockDetectSelect = func_reg[synth_ctrl_pkg::LOCK_SEL_BIT];
    case (lock_count_select)
      2'h0: settingsNext.lockThreshold = synth_ctrl_pkg::LOCK_CNT_7;
      2'h1: settingsNext.lockThreshold = synth_ctrl_pkg::LOCK_CNT_15;
      2'h2: settingsNext.lockThreshold = synth_ctrl_pkg::LOCK_CNT_31;
      default: settingsNext.lockThreshold = synth_ctrl_pkg::LOCK_CNT_63;
    endcase
    // Code 00 is forbidden to the host; it yields modulus zero
    case (prescaleCode)
      2'h1: settingsNext.prescaleModulus = synth_ctrl_pkg::PRESCALE_16;
      2'h2: settingsNext.prescaleModulus = synth_ctrl_pkg::PRESCALE_32;
      2'h3: settingsNext.prescaleModulus = synth_ctrl_pkg::PRESCALE_64;
      default: settingsNext.prescaleModulus = 7'h00;
    endcase
    // Range 4..16383 is the host's duty; passed through unchecked
    settingsNext.refDivider = refLive_reg[synth_ctrl_pkg::REF_DIV_LSB +: 14];
    settingsNext.dividerCount = divLive_reg;
    settingsNext.fastActive = fast_lock_enable && fastActive;
  end

  // Output register
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      settings <= '0;
    end else begin
      settings <= settingsNext;
    end
  end

endmodule

// file: common/synth_ctrl_pkg.sv
// Package for the synthesizer control register bank.
// Assumes a 20-bit data word plus a 4-bit address per serial write.
package synth_ctrl_pkg;

  // ==========================================================
  // Word layout and addresses
  localparam int DATA_BITS = 20;
  localparam int ADDR_BITS = 4;
  localparam int FRAME_BITS = DATA_BITS + ADDR_BITS;
  localparam logic [3:0] ADDR_DIVIDER = 4'h1;
  localparam logic [3:0] ADDR_PUMP = 4'h2;
  localparam logic [3:0] ADDR_REFPRE = 4'h3;
  localparam logic [3:0] ADDR_FUNCTION = 4'h4;
  localparam logic [3:0] ADDR_GENOUT = 4'h5;

  // ==========================================================
  // Field positions
  localparam int NORMAL_CUR_LSB = 0;
  localparam int FAST_CUR_LSB = 6;
  localparam int REF_DIV_LSB = 0;
  localparam int PRESCALE_LSB = 14;
  localparam int FAST_DUR_LSB = 0;
  localparam int LOCK_SEL_BIT = 13;
  localparam int POLARITY_BIT = 14;
  localparam int TRISTATE_BIT = 15;
  localparam int FAST_EN_BIT = 16;
  localparam int LOCK_CNT_LSB = 17;
  localparam int GEN_ONE_BIT = 0;
  localparam int GEN_TWO_BIT = 1;

  // ==========================================================
  // Reset values (contents are undefined on the part; zero here)
  localparam logic [19:0] WORD_RESET = 20'h00000;
  localparam logic [12:0] DUR_RESET = 13'h0000;

  // Pump current codes: 0..7 give (code+1) steps, 8 gives half a step
  localparam logic [3:0] CUR_HALF_CODE = 4'h8;
  localparam logic [3:0] CUR_MAX_LINEAR = 4'h7;

  // Prescaler moduli and lock thresholds
  localparam logic [6:0] PRESCALE_16 = 7'h10;
  localparam logic [6:0] PRESCALE_32 = 7'h20;
  localparam logic [6:0] PRESCALE_64 = 7'h40;
  localparam logic [5:0] LOCK_CNT_7 = 6'h07;
  localparam logic [5:0] LOCK_CNT_15 = 6'h0f;
  localparam logic [5:0] LOCK_CNT_31 = 6'h1f;
  localparam logic [5:0] LOCK_CNT_63 = 6'h3f;

  // Settings as applied to the analog side
  typedef struct packed {
    logic [3:0] activeCurCode;  // Code actually steering the pump
    logic [4:0] curHalfSteps;   // Current in half minimum steps
    logic pumpTristate;
    logic pumpPolarity;         // 0 positive, 1 negative
    logic lockDetectSelect;     // 0 digital, 1 analog
    logic [5:0] lockThreshold;
    logic [6:0] prescaleModulus;
    logic [13:0] refDivider;
    logic [18:0] dividerCount;  // B then A counts
    logic fastActive;
  } synth_settings_t;

  typedef enum logic [1:0] {FastIdle, FastRun, FastDone} fast_state_t;

endpackage

// file: rtl/fast_lock_timer.sv
// Counts phase detector ticks during fast lockup.
// Assumes pdTick is a one-cycle pulse per phase detector period.
`timescale 1ns/100ps
module fast_lock_timer #(
  parameter int DUR_BITS = 13
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstSync_n,
  // Control
  input wire logic start,
  input wire logic enable,
  input wire logic pdTick,
  input wire logic [DUR_BITS-1:0] duration,
  // Status
  output logic active
);

  synth_ctrl_pkg::fast_state_t state_reg;
  logic [DUR_BITS-1:0] count_reg;

  // ==========================================================
  // Timer state; restart wins over expiry
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_reg <= synth_ctrl_pkg::FastIdle;
      count_reg <= synth_ctrl_pkg::DUR_RESET;
    end else if (start && enable) begin
      state_reg <= synth_ctrl_pkg::FastRun;
      count_reg <= duration;
    end else if (!enable) begin
      state_reg <= synth_ctrl_pkg::FastIdle;
    end else begin
      case (state_reg)
        synth_ctrl_pkg::FastRun: begin
          // Count down per phase detector cycle, off at zero
          if (pdTick) begin
            if (count_reg <= DUR_BITS'(1)) begin
              state_reg <= synth_ctrl_pkg::FastDone;
            end
            count_reg <= count_reg - DUR_BITS'(1);
          end
        end
        synth_ctrl_pkg::FastIdle: state_reg <= synth_ctrl_pkg::FastIdle;
        synth_ctrl_pkg::FastDone: state_reg <= synth_ctrl_pkg::FastDone;
        default: state_reg <= synth_ctrl_pkg::FastIdle;
      endcase
    end
  end

  assign active = (state_reg == synth_ctrl_pkg::FastRun);

endmodule

// file: sim/serial_host.sv
// Host model that writes frames over the three-wire serial link.
// Assumes the bench calls send only after reset has been released.
`timescale 1ns/100ps
module serial_host (
  // Clock
  input wire logic core_clk,
  // Serial link
  output logic serialClk,
  output logic serialData,
  output logic latch_enable
);
  // Link idles with the clock stopped low
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    latch_enable = 1'b0;
  end
  // Each level held two cycles so the core clock sees every edge
  task automatic send(input logic [3:0] a, input logic [19:0] d);
    logic [23:0] f;
    f = {d, a};
    @(posedge core_clk);
    for (int i = 23; i >= 0; i--) begin
      #1 serialClk = 1'b0;
      serialData = f[i];
      repeat (2) @(posedge core_clk);
      #1 serialClk = 1'b1;
      repeat (2) @(posedge core_clk);
    end
    // Released data line shows the inverse, not the last bit
    #1 serialClk = 1'b0;
    serialData = ~f[0];
    repeat (2) @(posedge core_clk);
    #1 latch_enable = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 latch_enable = 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// file: sim/synth_control_registers_asserts.sv
// Concurrent checks on the register bank ports.
// Assumes it is bound onto synth_control_registers.
`timescale 1ns/100ps
module synth_control_registers_asserts #(
  parameter int DUR_BITS = 13
) (
  // Watched ports
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic latch_enable,
  input wire logic pdTick,
  input wire synth_ctrl_pkg::synth_settings_t settings,
  input wire logic general_output_one,
  input wire logic general_output_two
);
  // ==========================================================
  // Frame decoder, a private copy of what the host sent
  logic sclkQ, leQ, got;
  logic [23:0] sh, frm;
  logic [19:0] pBuf, rBuf, fBuf;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkQ <= 1'b0;
      leQ <= 1'b0;
      got <= 1'b0;
    end else begin
      sclkQ <= serialClk;
      leQ <= latch_enable;
      got <= latch_enable && !leQ;
    end
  end
  // Data copies need no reset: every use waits for a frame
  always_ff @(posedge core_clk) begin
    if (serialClk && !sclkQ) sh <= {sh[22:0], serialData};
    if (latch_enable && !leQ) frm <= sh;
    if (got && frm[3:0] == 4'h2) pBuf <= frm[23:4];
    if (got && frm[3:0] == 4'h3) rBuf <= frm[23:4];
    if (got && frm[3:0] == 4'h4) fBuf <= frm[23:4];
  end
  function automatic logic [4:0] halfs(input logic [3:0] c);
    return (c < 4'h8) ? {c, 1'b0} + 5'h02 : {4'h0, c == 4'h8};
  endfunction
  wire [6:0] thr = (7'h08 << frm[22:21]) - 7'h01;
  wire [6:0] pre = (rBuf[15:14] == 2'h0) ? 7'h00 : 7'h08 << rBuf[15:14];
  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence frame_s(logic [3:0] a);
    got && frm[3:0] == a;
  endsequence
  chk_out_one_level: assert property (
    frame_s(4'h5) |-> ##3 general_output_one == frm[4]) else $error("output one wrong");
  chk_out_two_level: assert property (
    frame_s(4'h5) |-> ##3 general_output_two == frm[5]) else $error("output two wrong");
  chk_pump_mode_bits: assert property (
    frame_s(4'h4) |-> ##3 settings.pumpTristate == frm[19] && settings.pumpPolarity == frm[18]
    && settings.lockDetectSelect == frm[17]) else $error("function bits wrong");
  chk_lock_threshold: assert property (
    frame_s(4'h4) |-> ##3 settings.lockThreshold == thr[5:0]) else $error("threshold wrong");
  chk_buffer_hold: assert property (
    got && (frm[3:0] == 4'h2 || frm[3:0] == 4'h3) |-> ##1 ($stable(settings.refDivider)
    && $stable(settings.activeCurCode) && $stable(settings.curHalfSteps)
    && $stable(settings.prescaleModulus) && $stable(settings.dividerCount))[*4])
    else $error("buffered word applied early");
  chk_commit_divider: assert property (
    frame_s(4'h1) |-> ##3 settings.dividerCount == frm[22:4]
    && settings.refDivider == rBuf[13:0]) else $error("commit wrong");
  chk_prescale_code: assert property (
    frame_s(4'h1) |-> ##3 settings.prescaleModulus == pre) else $error("prescaler wrong");
  chk_normal_current: assert property (
    frame_s(4'h1) ##0 !fBuf[16] |-> ##3 !settings.fastActive
    && settings.activeCurCode == pBuf[3:0] && settings.curHalfSteps == halfs(pBuf[3:0]))
    else $error("normal current wrong");
  chk_fast_current: assert property (
    frame_s(4'h1) ##0 (fBuf[16] && !pdTick)[*5] |-> settings.fastActive
    && settings.activeCurCode == pBuf[9:6] && settings.curHalfSteps == halfs(pBuf[9:6]))
    else $error("fast current wrong");
endmodule
bind synth_control_registers synth_control_registers_asserts #(.DUR_BITS(DUR_BITS)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .serialClk(serialClk), .serialData(serialData),
  .latch_enable(latch_enable), .pdTick(pdTick), .settings(settings),
  .general_output_one(general_output_one), .general_output_two(general_output_two));

// file: sim/synth_control_registers_tb.sv
// Self-checking bench for the synthesizer control registers.
// Assumes serial_host drives the link and the checker is bound in.
`timescale 1ns/100ps
module synth_control_registers_tb;
  // ==========================================================
  // Signals and reference state
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pdTick = 1'b0;
  logic serialClk, serialData, latch_enable, general_output_one, general_output_two;
  synth_ctrl_pkg::synth_settings_t settings;
  int n_mismatch = 0;
  int cmp_count = 0;
  int ticks = 0;
  logic [31:0] seed = 32'had5932ef;
  logic [19:0] pB = '0, rB = '0, pA = '0, rA = '0, fW = '0, gW = '0;
  logic [18:0] dA = '0;
  logic fast = 1'b0;
  synth_ctrl_pkg::synth_settings_t expSet[$];
  logic [1:0] expPin[$];
  event chk;
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  serial_host host (.core_clk(core_clk), .serialClk(serialClk), .serialData(serialData),
    .latch_enable(latch_enable));
  synth_control_registers #(.DUR_BITS(13)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .serialClk(serialClk), .serialData(serialData), .latch_enable(latch_enable),
    .pdTick(pdTick), .settings(settings), .general_output_one(general_output_one),
    .general_output_two(general_output_two));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected outputs follow from the applied copies only
  task automatic note();
    synth_ctrl_pkg::synth_settings_t e;
    logic [3:0] c;
    c = fast ? pA[9:6] : pA[3:0];
    e.activeCurCode = c;
    e.curHalfSteps = (c < 4'h8) ? {c, 1'b0} + 5'h02 : {4'h0, c == 4'h8};
    e.pumpTristate = fW[15];
    e.pumpPolarity = fW[14];
    e.lockDetectSelect = fW[13];
    e.lockThreshold = 6'((7'h08 << fW[18:17]) - 7'h01);
    e.prescaleModulus = (rA[15:14] == 2'h0) ? 7'h00 : 7'h08 << rA[15:14];
    e.refDivider = rA[13:0];
    e.dividerCount = dA;
    e.fastActive = fast;
    expSet.push_back(e);
    expPin.push_back(gW[1:0]);
    ->chk;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    host.send(a, d);
    case (a)
      4'h1: begin
        dA = d[18:0];
        pA = pB;
        rA = rB;
        fast = fW[16];
        ticks = 0;
      end
      4'h2: pB = d;
      4'h3: rB = d;
      4'h4: begin
        fW = d;
        if (!d[16]) fast = 1'b0;
      end
      4'h5: gW = d;
      default: ;
    endcase
    note();
  endtask
  task automatic tick();
    @(posedge core_clk) #1 pdTick = 1'b1;
    @(posedge core_clk) #1 pdTick = 1'b0;
    ticks++;
    if (fast && ticks == int'(fW[12:0])) fast = 1'b0;
  endtask
  task automatic cmp_set(input synth_ctrl_pkg::synth_settings_t g, e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %0t settings %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [1:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %0t outputs %b expected %b", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Output watcher, settled well after each write
  initial begin
    forever begin
      @(chk);
      repeat (6) @(posedge core_clk);
      #2;
      cmp_set(settings, expSet.pop_front());
      cmp_pin({general_output_two, general_output_one}, expPin.pop_front());
    end
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge core_clk);
    n_mismatch++;
    $display("mismatch %0t run did not finish", $time);
    wrap_up();
  end
  // Main sequence: function, pump and reference words written before each commit in the loop
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      wr(4'h4, {1'b0, i[1:0], 1'b0, r[2:0], r[31:19] | 13'h0001});
      wr(4'h2, {10'h000, 4'(r[7:4] % 4'h9), 2'h0, i[3:0]});
      wr(4'h3, {4'h0, 2'(i % 3 + 1), r[13:0] | 14'h0004});
      wr(4'h1, {1'b0, r[18:6] | 13'h0040, r[5:0]});
      wr(4'h5, {18'h00000, i[1:0]});
      wr(i[0] ? 4'h0 : 4'(7 + i), r[19:0]);
    end
    wr(4'h2, 20'h00142);
    wr(4'h4, 20'h10003);
    wr(4'h1, 20'h01043);
    repeat (2) tick();
    note();
    tick();
    note();
    wr(4'h1, 20'h01043);
    wr(4'h4, 20'h00003);
    wrap_up();
  end
endmodule
